// ==== hdl/port_a_mux_pkg.sv ====
`default_nettype none
package port_a_mux_pkg;
	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam int unsigned NUM_PINS       = 16;         // Port A width
	localparam int unsigned ADDR_W         = 14;         // Byte address bits
	localparam logic [11:0] DIR_INDEX      = 12'h0c4;    // Direction index
	localparam logic [11:0] HIGH_SEL_INDEX = 12'h0c8;    // Pins 15..8 select
	localparam logic [11:0] LOW_SEL_INDEX  = 12'h0ca;    // Pins 7..0 select
	localparam logic [13:0] DIR_ADDR       = {DIR_INDEX, 2'b00};
	localparam logic [13:0] HIGH_SEL_ADDR  = {HIGH_SEL_INDEX, 2'b00};
	localparam logic [13:0] LOW_SEL_ADDR   = {LOW_SEL_INDEX, 2'b00};

	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [15:0] DIR_RESET      = 16'h0000;
	localparam logic [15:0] HIGH_SEL_RESET = 16'h3302;
	localparam logic [15:0] LOW_SEL_RESET  = 16'hff95;

	// -----------------------------------------------------------------
	// High select field positions
	// -----------------------------------------------------------------
	localparam int unsigned PIN15_SEL_LSB  = 14;
	localparam int unsigned PIN14_SEL_LSB  = 12;
	localparam int unsigned PIN13_SEL_LSB  = 10;
	localparam int unsigned PIN12_SEL_LSB  = 8;
	localparam int unsigned PIN11_SEL_LSB  = 6;
	localparam int unsigned PIN10_SEL_LSB  = 4;
	localparam int unsigned PIN9_SEL_LSB   = 2;
	localparam int unsigned HIGH_RSVD_BIT  = 1;          // Reads as one
	localparam int unsigned PIN8_SEL_BIT   = 0;

	// -----------------------------------------------------------------
	// Role codes of a two-bit select field
	// -----------------------------------------------------------------
	localparam logic [1:0]  ROLE_GPIO      = 2'h0;
	localparam logic [1:0]  ROLE_ALT1      = 2'h1;
	localparam logic [1:0]  ROLE_ALT2      = 2'h2;
	localparam logic [1:0]  ROLE_ALT3      = 2'h3;
endpackage
`default_nettype wire

// ==== hdl/pin_route_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bundle between register core and role router
interface pin_route_if;
	logic [15:0] dir;           // Direction register
	logic [15:0] hsel;          // High select register
	logic [15:0] gpio_data;     // General output data
	logic [15:0] pad_in;        // Synchronised pad levels
	logic [1:0]  dack;          // DMA acknowledge from controller
	logic        tmr_a_out;     // Timer ch1 A compare out
	logic        tmr_b_out;     // Timer ch1 B compare out
	logic        par_hi_out;    // Upper parity out
	logic        par_hi_oe;     // Upper parity drive
	logic        par_lo_out;    // Lower parity out
	logic        par_lo_oe;     // Lower parity drive
	logic        ah_out;        // Address hold out
	logic        irq_out;       // Interrupt request out
	logic [15:0] next_pad_out;  // Pad data to register
	logic [15:0] next_pad_oe;   // Pad enable to register
	logic [3:0]  next_int;      // External interrupt inputs
	logic [1:0]  next_dreq;     // DMA request inputs
	logic        next_timer_ext_clock_a;    // Timer clock A
	logic        next_timer_ext_clock_b;    // Timer clock B
	logic        next_tmr_a_in; // Timer ch1 A capture in
	logic        next_tmr_b_in; // Timer ch1 B capture in
	logic        next_par_hi;   // Upper parity in
	logic        next_par_lo;   // Lower parity in
	logic        next_trig;     // Converter trigger
	logic        next_bus_request_in;     // Bus request
	modport router (
		input  dir, hsel, gpio_data, pad_in, dack, tmr_a_out, tmr_b_out,
		input  par_hi_out, par_hi_oe, par_lo_out, par_lo_oe, ah_out, irq_out,
		output next_pad_out, next_pad_oe, next_int, next_dreq, next_timer_ext_clock_a,
		output next_timer_ext_clock_b, next_tmr_a_in, next_tmr_b_in, next_par_hi,
		output next_par_lo, next_trig, next_bus_request_in
	);
	modport core (
		output dir, hsel, gpio_data, pad_in, dack, tmr_a_out, tmr_b_out,
		output par_hi_out, par_hi_oe, par_lo_out, par_lo_oe, ah_out, irq_out,
		input  next_pad_out, next_pad_oe, next_int, next_dreq, next_timer_ext_clock_a,
		input  next_timer_ext_clock_b, next_tmr_a_in, next_tmr_b_in, next_par_hi,
		input  next_par_lo, next_trig, next_bus_request_in
	);
endinterface
`default_nettype wire

// ==== hdl/pin_role_router.sv ====
`timescale 1ns/1ps
`default_nettype none
// Combinational role routing for pins 15..8
module pin_role_router
	import port_a_mux_pkg::*;
(
	pin_route_if.router r
);
	// -----------------------------------------------------------------
	// Role decode per pin
	// -----------------------------------------------------------------
	// Defaults: general I/O under direction control; peripherals see 0
	always_comb begin
		r.next_pad_out  = r.gpio_data;
		r.next_pad_oe   = r.dir;
		r.next_int      = 4'h0;
		r.next_dreq     = 2'h0;
		r.next_timer_ext_clock_a    = 1'b0;
		r.next_timer_ext_clock_b    = 1'b0;
		r.next_tmr_a_in = 1'b0;
		r.next_tmr_b_in = 1'b0;
		r.next_par_hi   = 1'b0;
		r.next_par_lo   = 1'b0;
		r.next_trig     = 1'b0;
		r.next_bus_request_in     = 1'b0;
		// Pin 15; reserved code stays general I/O
		case (r.hsel[PIN15_SEL_LSB +: 2])
			ROLE_ALT1: begin
				r.next_pad_oe[15] = 1'b0;
				r.next_int[3]     = r.pad_in[15];
			end
			ROLE_ALT3: begin
				r.next_pad_oe[15] = 1'b0;
				r.next_dreq[1]    = r.pad_in[15];
			end
			default: ;
		endcase
		// Pin 14
		case (r.hsel[PIN14_SEL_LSB +: 2])
			ROLE_ALT1: begin
				r.next_pad_oe[14] = 1'b0;
				r.next_int[2]     = r.pad_in[14];
			end
			ROLE_ALT3: begin
				r.next_pad_oe[14]  = 1'b1;
				r.next_pad_out[14] = r.dack[1];
			end
			default: ;
		endcase
		// Pin 13
		case (r.hsel[PIN13_SEL_LSB +: 2])
			ROLE_ALT1: begin
				r.next_pad_oe[13] = 1'b0;
				r.next_int[1]     = r.pad_in[13];
			end
			ROLE_ALT2: begin
				r.next_pad_oe[13] = 1'b0;
				r.next_timer_ext_clock_b      = r.pad_in[13];
			end
			ROLE_ALT3: begin
				r.next_pad_oe[13] = 1'b0;
				r.next_dreq[0]    = r.pad_in[13];
			end
			default: ;
		endcase
		// Pin 12
		case (r.hsel[PIN12_SEL_LSB +: 2])
			ROLE_ALT1: begin
				r.next_pad_oe[12] = 1'b0;
				r.next_int[0]     = r.pad_in[12];
			end
			ROLE_ALT2: begin
				r.next_pad_oe[12] = 1'b0;
				r.next_timer_ext_clock_a      = r.pad_in[12];
			end
			ROLE_ALT3: begin
				r.next_pad_oe[12]  = 1'b1;
				r.next_pad_out[12] = r.dack[0];
			end
			default: ;
		endcase
		// Pin 11; timer keeps direction register control
		case (r.hsel[PIN11_SEL_LSB +: 2])
			ROLE_ALT1: begin
				r.next_pad_oe[11]  = r.par_hi_oe;
				r.next_pad_out[11] = r.par_hi_out;
				r.next_par_hi      = r.pad_in[11];
			end
			ROLE_ALT2: begin
				r.next_pad_out[11] = r.tmr_b_out;
				r.next_tmr_b_in    = r.pad_in[11];
			end
			default: ;
		endcase
		// Pin 10
		case (r.hsel[PIN10_SEL_LSB +: 2])
			ROLE_ALT1: begin
				r.next_pad_oe[10]  = r.par_lo_oe;
				r.next_pad_out[10] = r.par_lo_out;
				r.next_par_lo      = r.pad_in[10];
			end
			ROLE_ALT2: begin
				r.next_pad_out[10] = r.tmr_a_out;
				r.next_tmr_a_in    = r.pad_in[10];
			end
			default: ;
		endcase
		// Pin 9
		case (r.hsel[PIN9_SEL_LSB +: 2])
			ROLE_ALT1: begin
				r.next_pad_oe[9]  = 1'b1;
				r.next_pad_out[9] = r.ah_out;
			end
			ROLE_ALT2: begin
				r.next_pad_oe[9] = 1'b0;
				r.next_trig      = r.pad_in[9];
			end
			ROLE_ALT3: begin
				r.next_pad_oe[9]  = 1'b1;
				r.next_pad_out[9] = r.irq_out;
			end
			default: ;
		endcase
		// Pin 8: single-bit select
		if (r.hsel[PIN8_SEL_BIT]) begin
			r.next_pad_oe[8] = 1'b0;
			r.next_bus_request_in      = r.pad_in[8];
		end
	end
endmodule
`default_nettype wire

// ==== hdl/port_a_pin_function_mux.sv ====
// Behaviour
// - Direction register: 16 bits, 1 output, 0 input
// - Direction applies only to general I/O, timer
// - Power-on reset clears direction; others keep it
// - High/low select registers, pins 15..8 / 7..0
// - Select registers reset to 3302 and ff95
// - Pin 15: gpio, interrupt 3, -, DMA request 1
// - Pin 14: gpio, interrupt 2, -, DMA acknowledge 1
// - Pin 13: gpio, interrupt 1, timer clock B, DMA request 0
// - Pin 12: gpio, interrupt 0, timer clock A, DMA ack 0
// - Pin 11: gpio, upper parity, timer capture B
// - Pin 10: gpio, lower parity, timer capture A
// - Pin 9: gpio, address hold, trigger, interrupt out
// - High select bit 1 reads one; write one
// - Pin 8: gpio or bus request input
`timescale 1ns/1ps
`default_nettype none
module port_a_pin_function_mux
	import port_a_mux_pkg::*;
#(
	parameter int unsigned PADDR_W = ADDR_W  // APB address width
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [PADDR_W-1:0]         paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic [port_a_mux_pkg::NUM_PINS-1:0] pad_in,
	output logic      [port_a_mux_pkg::NUM_PINS-1:0] pad_out,
	output logic      [port_a_mux_pkg::NUM_PINS-1:0] pad_oe,
	input  wire logic [port_a_mux_pkg::NUM_PINS-1:0] gpio_out_data,
	output logic      [port_a_mux_pkg::NUM_PINS-1:0] gpio_in_data,
	output logic      [3:0]                 ext_int_req,
	output logic      [1:0]                 dma_request_in,
	input  wire logic [1:0]                 dma_acknowledge_out,
	output logic                            timer_ext_clock_a,
	output logic                            timer_ext_clock_b,
	input  wire logic                       timer_ch1_capcmp_a_out,
	input  wire logic                       timer_ch1_capcmp_b_out,
	output logic                            timer_ch1_capcmp_a_in,
	output logic                            timer_ch1_capcmp_b_in,
	input  wire logic                       parity_upper_byte_out,
	input  wire logic                       parity_upper_byte_oe,
	output logic                            parity_upper_byte_in,
	input  wire logic                       parity_lower_byte_out,
	input  wire logic                       parity_lower_byte_oe,
	output logic                            parity_lower_byte_in,
	input  wire logic                       address_hold_out,
	input  wire logic                       interrupt_request_out,
	output logic                            converter_trigger_in,
	output logic                            bus_request_in
);
	// -----------------------------------------------------------------
	// Elaboration checks
	// -----------------------------------------------------------------
	if (PADDR_W < ADDR_W) begin : g_bad_width
		$error("paddr too narrow for the register map");
	end

	// -----------------------------------------------------------------
	// Registers and next values
	// -----------------------------------------------------------------
	logic [15:0] porta_direction;              // Direction register
	logic [15:0] porta_high_function_select;   // Pins 15..8 roles
	logic [15:0] porta_low_function_select;    // Pins 7..0 roles
	logic [15:0] next_direction;               // Next direction
	logic [15:0] next_high_sel;                // Next high select
	logic [15:0] next_low_sel;                 // Next low select
	logic [31:0] next_prdata;                  // Next read data
	logic        next_pready;                  // Next ready
	logic        next_pslverr;                 // Next error
	logic [15:0] pad_meta;                     // Synchroniser stage one
	logic [15:0] pad_sync;                     // Synchroniser stage two
	logic        access_first;                 // First access cycle
	logic        access_done;                  // Completing edge
	logic        hit_dir;                      // Direction decode
	logic        hit_high;                     // High select decode
	logic        hit_low;                      // Low select decode
	logic [13:0] addr;                         // Used address bits

	pin_route_if route ();                     // Core to router bundle

	// -----------------------------------------------------------------
	// Pad input synchroniser
	// -----------------------------------------------------------------
	// Two flops before any routing reads a pad
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_meta <= 16'h0000;
			pad_sync <= 16'h0000;
		end else begin
			pad_meta <= pad_in;
			pad_sync <= pad_meta;
		end
	end

	// -----------------------------------------------------------------
	// APB decode
	// -----------------------------------------------------------------
	// One wait state: ready rises in the second access cycle
	always_comb begin
		addr         = paddr[13:0];
		access_first = psel && penable && !pready;
		access_done  = psel && penable && pready;
		hit_dir      = (addr == DIR_ADDR);
		hit_high     = (addr == HIGH_SEL_ADDR);
		hit_low      = (addr == LOW_SEL_ADDR);
	end

	// -----------------------------------------------------------------
	// Register next values
	// -----------------------------------------------------------------
	// Writes land on the completing edge, per byte lane
	always_comb begin
		next_direction = porta_direction;
		next_high_sel  = porta_high_function_select;
		next_low_sel   = porta_low_function_select;
		next_pready    = access_first;
		next_pslverr   = access_first && !(hit_dir || hit_high || hit_low);
		next_prdata    = 32'h0000_0000;
		if (access_first && !pwrite) begin
			// Read mux; unmapped reads zero
			if (hit_dir) begin
				next_prdata[15:0] = porta_direction;
			end else if (hit_high) begin
				next_prdata[15:0] = porta_high_function_select;
			end else if (hit_low) begin
				next_prdata[15:0] = porta_low_function_select;
			end
		end
		if (access_done && pwrite) begin
			// Direction register write
			if (hit_dir) begin
				if (pstrb[0]) next_direction[7:0] = pwdata[7:0];
				if (pstrb[1]) next_direction[15:8] = pwdata[15:8];
			end
			// High select write
			if (hit_high) begin
				if (pstrb[0]) next_high_sel[7:0] = pwdata[7:0];
				if (pstrb[1]) next_high_sel[15:8] = pwdata[15:8];
			end
			// Low select write
			if (hit_low) begin
				if (pstrb[0]) next_low_sel[7:0] = pwdata[7:0];
				if (pstrb[1]) next_low_sel[15:8] = pwdata[15:8];
			end
		end
		// Reserved bit holds one whatever is written
		next_high_sel[HIGH_RSVD_BIT] = 1'b1;
	end

	// -----------------------------------------------------------------
	// Register state
	// -----------------------------------------------------------------
	// Only power-on reset initialises; no other reset source here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			porta_direction            <= DIR_RESET;
			porta_high_function_select <= HIGH_SEL_RESET;
			porta_low_function_select  <= LOW_SEL_RESET;
			prdata                     <= 32'h0000_0000;
			pready                     <= 1'b0;
			pslverr                    <= 1'b0;
		end else begin
			porta_direction            <= next_direction;
			porta_high_function_select <= next_high_sel;
			porta_low_function_select  <= next_low_sel;
			prdata                     <= next_prdata;
			pready                     <= next_pready;
			pslverr                    <= next_pslverr;
		end
	end

	// -----------------------------------------------------------------
	// Router hookup
	// -----------------------------------------------------------------
	// Feeds the role router with state and peripheral signals
	always_comb begin
		route.dir        = porta_direction;
		route.hsel       = porta_high_function_select;
		route.gpio_data  = gpio_out_data;
		route.pad_in     = pad_sync;
		route.dack       = dma_acknowledge_out;
		route.tmr_a_out  = timer_ch1_capcmp_a_out;
		route.tmr_b_out  = timer_ch1_capcmp_b_out;
		route.par_hi_out = parity_upper_byte_out;
		route.par_hi_oe  = parity_upper_byte_oe;
		route.par_lo_out = parity_lower_byte_out;
		route.par_lo_oe  = parity_lower_byte_oe;
		route.ah_out     = address_hold_out;
		route.irq_out    = interrupt_request_out;
	end

	pin_role_router u_router (
		.r (route.router)
	);

	// -----------------------------------------------------------------
	// Output registers
	// -----------------------------------------------------------------
	// Every pin and peripheral output leaves from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out               <= 16'h0000;
			pad_oe                <= 16'h0000;
			gpio_in_data          <= 16'h0000;
			ext_int_req           <= 4'h0;
			dma_request_in        <= 2'h0;
			timer_ext_clock_a     <= 1'b0;
			timer_ext_clock_b     <= 1'b0;
			timer_ch1_capcmp_a_in <= 1'b0;
			timer_ch1_capcmp_b_in <= 1'b0;
			parity_upper_byte_in  <= 1'b0;
			parity_lower_byte_in  <= 1'b0;
			converter_trigger_in  <= 1'b0;
			bus_request_in        <= 1'b0;
		end else begin
			pad_out               <= route.next_pad_out;
			pad_oe                <= route.next_pad_oe;
			gpio_in_data          <= pad_sync;
			ext_int_req           <= route.next_int;
			dma_request_in        <= route.next_dreq;
			timer_ext_clock_a     <= route.next_timer_ext_clock_a;
			timer_ext_clock_b     <= route.next_timer_ext_clock_b;
			timer_ch1_capcmp_a_in <= route.next_tmr_a_in;
			timer_ch1_capcmp_b_in <= route.next_tmr_b_in;
			parity_upper_byte_in  <= route.next_par_hi;
			parity_lower_byte_in  <= route.next_par_lo;
			converter_trigger_in  <= route.next_trig;
			bus_request_in        <= route.next_bus_request_in;
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	a_dir_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		(access_done && pwrite && hit_dir && pstrb[1:0] == 2'h3)
			|=> porta_direction == $past(pwdata[15:0]))
		else $error("direction write not stored");

	a_gpio_follows_dir: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN15_SEL_LSB +: 2] == ROLE_GPIO)
			|=> pad_oe[15] == $past(porta_direction[15]))
		else $error("general pin ignores direction");

	a_dir_ignored: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN15_SEL_LSB +: 2] == ROLE_ALT1)
			|=> !pad_oe[15])
		else $error("interrupt pin is driven");

	a_select_reset: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> porta_high_function_select == HIGH_SEL_RESET
			&& porta_low_function_select == LOW_SEL_RESET
			&& porta_direction == DIR_RESET)
		else $error("wrong reset values");

	a_rsvd_reads_one: assert property (
		@(posedge pclk) disable iff (!presetn)
		(access_first && !pwrite && hit_high) |=> prdata[HIGH_RSVD_BIT])
		else $error("reserved bit read as zero");

	a_pin14_dack: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN14_SEL_LSB +: 2] == ROLE_ALT3)
			|=> pad_oe[14] && pad_out[14] == $past(dma_acknowledge_out[1]))
		else $error("acknowledge not on pin 14");

	a_pin13_tclk: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN13_SEL_LSB +: 2] == ROLE_ALT2)
			|=> timer_ext_clock_b == $past(pad_sync[13]))
		else $error("timer clock B not from pin 13");

	a_pin9_trigger: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN9_SEL_LSB +: 2] != ROLE_ALT2)
			|=> !converter_trigger_in)
		else $error("trigger leaks from pin 9");

	a_pin8_bus_request_in: assert property (
		@(posedge pclk) disable iff (!presetn)
		porta_high_function_select[PIN8_SEL_BIT] |=> !pad_oe[8]
			&& bus_request_in == $past(pad_sync[8]))
		else $error("bus request routing wrong");

	a_apb_one_wait: assert property (
		@(posedge pclk) disable iff (!presetn)
		access_first |=> pready ##1 !pready)
		else $error("answer not after one wait");

	a_pin15_dreq: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN15_SEL_LSB +: 2] == ROLE_ALT3)
			|=> !pad_oe[15] && dma_request_in[1] == $past(pad_sync[15]))
		else $error("DMA request not from pin 15");

	a_pin14_irq: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN14_SEL_LSB +: 2] == ROLE_ALT1)
			|=> !pad_oe[14] && ext_int_req[2] == $past(pad_sync[14]))
		else $error("interrupt 2 not from pin 14");

	a_pin12_tclk: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN12_SEL_LSB +: 2] == ROLE_ALT2)
			|=> !pad_oe[12] && timer_ext_clock_a == $past(pad_sync[12]))
		else $error("timer clock A not from pin 12");

	a_pin11_parity: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN11_SEL_LSB +: 2] == ROLE_ALT1)
			|=> pad_oe[11] == $past(parity_upper_byte_oe)
			&& pad_out[11] == $past(parity_upper_byte_out))
		else $error("upper parity not on pin 11");

	a_pin10_timer: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN10_SEL_LSB +: 2] == ROLE_ALT2)
			|=> pad_oe[10] == $past(porta_direction[10])
			&& pad_out[10] == $past(timer_ch1_capcmp_a_out))
		else $error("timer A compare not on pin 10");

	a_pin9_irq_out: assert property (
		@(posedge pclk) disable iff (!presetn)
		(porta_high_function_select[PIN9_SEL_LSB +: 2] == ROLE_ALT3)
			|=> pad_oe[9] && pad_out[9] == $past(interrupt_request_out))
		else $error("interrupt out not on pin 9");

	a_low_sel_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		(access_done && pwrite && hit_low && pstrb[1:0] == 2'h3)
			|=> porta_low_function_select == $past(pwdata[15:0]))
		else $error("low select write not stored");

	a_slverr_unmapped: assert property (
		@(posedge pclk) disable iff (!presetn)
		(access_first && !(hit_dir || hit_high || hit_low))
			|=> pready && pslverr)
		else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ==== test/pin_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far-side pins and peripherals; the level pattern shifts one LFSR place each cycle
module pin_partner (
	input  wire logic        pclk,
	input  wire logic        presetn,
	output var  logic [15:0] pad_in,
	output var  logic [9:0]  periph
);
	logic [25:0] lfsr; // Pattern source
	// Steps just after each rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lfsr <= 26'h2a5c3f1;
		else
			lfsr <= {lfsr[24:0], lfsr[25] ^ lfsr[5] ^ lfsr[1] ^ lfsr[0]};
	end
	assign pad_in = lfsr[15:0];  // Pin levels
	assign periph = lfsr[25:16]; // Dack, timer, parity, hold, irq
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import port_a_mux_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [13:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q, v, seed = 32'hf65d2d27;
	logic        pready, pslverr, e, chk = 0;
	logic [15:0] pad_in, pad_oe, gpio = '0, sdir = '0, shs = 16'h3302, pd1 = '0, pd2 = '0;
	logic [31:0] xpin = '0;
	logic [29:0] xper = '0;
	wire  [15:0] pout;
	wire  [29:0] pv;
	logic [9:0]  per;
	int          failures = 0, compares = 0;
	always #2 pclk = ~pclk;
	port_a_pin_function_mux port_a_pin_function_mux_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
		.pad_out(pout), .pad_oe(pad_oe), .gpio_out_data(gpio), .gpio_in_data(pv[29:14]),
		.ext_int_req(pv[13:10]), .dma_request_in(pv[9:8]), .dma_acknowledge_out(per[1:0]),
		.timer_ext_clock_a(pv[7]), .timer_ext_clock_b(pv[6]), .timer_ch1_capcmp_a_out(per[2]),
		.timer_ch1_capcmp_b_out(per[3]), .timer_ch1_capcmp_a_in(pv[5]),
		.timer_ch1_capcmp_b_in(pv[4]), .parity_upper_byte_out(per[4]),
		.parity_upper_byte_oe(per[5]), .parity_upper_byte_in(pv[3]),
		.parity_lower_byte_out(per[6]), .parity_lower_byte_oe(per[7]),
		.parity_lower_byte_in(pv[2]), .address_hold_out(per[8]),
		.interrupt_request_out(per[9]), .converter_trigger_in(pv[1]), .bus_request_in(pv[0]));
	pin_partner pin_partner_inst (.pclk(pclk), .presetn(presetn), .pad_in(pad_in), .periph(per));
	// Fixed-seed xorshift
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Expected pad data (upper half) and drive enables (lower half) of port A
	function automatic logic [31:0] exp_pin(logic [15:0] d, g, h, logic [9:0] p);
		logic [15:0] o, t;
		o = d;
		t = g;
		if (h[14]) o[15] = 1'b0;
		if (h[13:12] == 2'h1) o[14] = 1'b0;
		if (h[13:12] == 2'h3) {o[14], t[14]} = {1'b1, p[1]};
		if (h[11:10] != 2'h0) o[13] = 1'b0;
		if (h[9:8] == 2'h1 || h[9:8] == 2'h2) o[12] = 1'b0;
		if (h[9:8] == 2'h3) {o[12], t[12]} = {1'b1, p[0]};
		if (h[7:6] == 2'h1) {o[11], t[11]} = {p[5], p[4]};
		if (h[7:6] == 2'h2) t[11] = p[3];
		if (h[5:4] == 2'h1) {o[10], t[10]} = {p[7], p[6]};
		if (h[5:4] == 2'h2) t[10] = p[2];
		if (h[3:2] == 2'h2) o[9] = 1'b0;
		if (h[2]) {o[9], t[9]} = {1'b1, h[3] ? p[9] : p[8]};
		if (h[0]) o[8] = 1'b0;
		return {t, o};
	endfunction
	// Expected synchronised pin levels and peripheral inputs from pin levels s
	function automatic logic [29:0] exp_per(logic [15:0] h, logic [15:0] s);
		logic [29:0] o;
		o = {s, 14'h0};
		if (h[15:14] == 2'h1) o[13] = s[15];
		if (h[15:14] == 2'h3) o[9] = s[15];
		if (h[13:12] == 2'h1) o[12] = s[14];
		if (h[11:10] == 2'h1) o[11] = s[13];
		if (h[11:10] == 2'h2) o[6] = s[13];
		if (h[11:10] == 2'h3) o[8] = s[13];
		if (h[9:8] == 2'h1) o[10] = s[12];
		if (h[9:8] == 2'h2) o[7] = s[12];
		if (h[7:6] == 2'h1) o[3] = s[11];
		if (h[7:6] == 2'h2) o[4] = s[11];
		if (h[5:4] == 2'h1) o[2] = s[10];
		if (h[5:4] == 2'h2) o[5] = s[10];
		if (h[3:2] == 2'h2) o[1] = s[9];
		if (h[0]) o[0] = s[8];
		return o;
	endfunction
	task check(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// One APB transfer; shadow registers follow committed writes
	task apb(input logic w, input logic [13:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic err);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1); // Watchdog bounds the wait
		r = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
		if (w && !err && a == DIR_ADDR) sdir = d[15:0];
		if (w && !err && a == HIGH_SEL_ADDR) shs = d[15:0] | 16'h0002;
	endtask
	task results();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Pins and peripheral side checked every cycle against the shadow copy
	always @(negedge pclk) begin
		if (chk) begin
			check({pout, pad_oe}, xpin);
			check({2'h0, pv}, {2'h0, xper});
		end
		xpin = exp_pin(sdir, gpio, shs, per);
		xper = exp_per(shs, pd2);
		pd2 = pd1;
		pd1 = presetn ? pad_in : 16'h0; // Synchroniser holds zero in reset
	end
	initial begin
		#100000;
		failures++;
		results();
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk <= 1;
		apb(0, DIR_ADDR, 0, q, e); check(q, 32'h0);
		apb(0, HIGH_SEL_ADDR, 0, q, e); check(q, 32'h3302);
		apb(0, LOW_SEL_ADDR, 0, q, e); check(q, 32'hff95);
		apb(0, 14'h0004, 0, q, e); check({31'h0, e}, 32'h1);
		apb(1, LOW_SEL_ADDR, 32'h1234, q, e);
		apb(0, LOW_SEL_ADDR, 0, q, e); check(q, 32'h1234);
		$display("test reset values done");
		repeat (24) begin
			v = xs();
			v[15] &= v[14]; v[13] &= v[12]; v[7] &= ~v[6]; v[5] &= ~v[4]; v[1] = 1'b1;
			gpio <= v[31:16];
			apb(1, HIGH_SEL_ADDR, v, q, e);
			apb(1, DIR_ADDR, xs(), q, e);
			apb(0, HIGH_SEL_ADDR, 0, q, e); check(q, {16'h0, shs});
			apb(0, DIR_ADDR, 0, q, e); check(q, {16'h0, sdir});
			repeat (3) @(posedge pclk);
		end
		$display("test random roles done");
		results();
	end
endmodule
`default_nettype wire
